/* File: logic/sram_ddr_core.sv */
/*
  Burst-of-two separate-I/O DDR SRAM core: read port, write port with lane and nibble
  masks, output launch by output clocks or input clocks, coherency, drive-strength stepping.
  Assumes all memory clock pins are synchronous to ref_clk and far slower than it,
  so every rising edge is seen as one sampled transition.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Every input-clock rise samples the address and read select for the read port.
// - A captured read launches beat one on output-clock-n, beat two on output-clock.
// - A read deselect leaves both output beats in high impedance.
// - Write select samples on input-clock rise, write address on the following n rise.
// - First write beat is captured with the write command on the input-clock rise.
// - Second write beat is captured on the input-clock-n rise with the address.
// - A write deselect stores nothing.
// - Each mask is sampled with the data beat it qualifies.
// - A high lane mask leaves that nine-bit lane of the array untouched.
// - One write address covers two beats, one double-width array word.
// - Any lane may be masked independently in either beat.
// - In the narrow mode, nibble masks replace the lane masks.
// - Toggling output clocks fire the output registers.
// - With both output clocks held high, input clocks launch read data.
// - A cycle counter periodically triggers an impedance evaluation and restarts.
// - Each evaluation moves the drive code by at most one step.
// - A read after a completed write to the same address returns new data.
// - Same address read then written in one cycle forwards the incoming write data.
// - Masks at input-clock govern beat one, masks at input-clock-n beat two.
module sram_ddr_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic c_in,
  input wire logic c_n_in,
  input wire logic read_select_n,
  input wire logic write_select_n,
  input wire logic [sram_ddr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sram_ddr_pkg::DATA_W-1:0] data_in,
  input wire logic [sram_ddr_pkg::LANES-1:0] lane_write_mask,
  input wire logic [sram_ddr_pkg::NIBS-1:0] nibble_write_mask,
  input wire logic nibble_mode,
  input wire logic imp_above_ref,
  output logic [sram_ddr_pkg::DATA_W-1:0] q_out,
  output logic q_oe,
  output logic [sram_ddr_pkg::CODE_W-1:0] drive_code
);

  // Per-bit write enable from the masks of one beat
  function automatic logic [sram_ddr_pkg::DATA_W-1:0] beat_enable(
    input sram_ddr_pkg::wbeat_s b,
    input logic nib
  );
    logic [sram_ddr_pkg::DATA_W-1:0] en;
    en = '0;
    if (nib) begin
      for (int i = 0; i < sram_ddr_pkg::NIBS; i++) begin
        en[i*sram_ddr_pkg::NIB_W +: sram_ddr_pkg::NIB_W] = {sram_ddr_pkg::NIB_W{~b.nmask[i]}};
      end
    end else begin
      for (int i = 0; i < sram_ddr_pkg::LANES; i++) begin
        en[i*sram_ddr_pkg::LANE_W +: sram_ddr_pkg::LANE_W] = {sram_ddr_pkg::LANE_W{~b.mask[i]}};
      end
    end
    return en;
  endfunction

  logic [sram_ddr_pkg::WORD_W-1:0] mem [sram_ddr_pkg::DEPTH];
  logic k_prev_r;
  logic k_n_prev_r;
  logic c_prev_r;
  logic c_n_prev_r;
  sram_ddr_pkg::rd_req_s rd_stage_r;
  sram_ddr_pkg::rd_data_s out_stage_r;
  sram_ddr_pkg::beat_phase_e phase_r;
  logic [sram_ddr_pkg::DATA_W-1:0] beat1_hold_r;
  logic beat1_valid_r;
  logic beat1_pend_r;
  logic kn_seen_r;
  logic kn_after_k_r;
  logic [sram_ddr_pkg::DATA_W-1:0] q_r;
  logic q_oe_r;
  logic wr_pend_r;
  sram_ddr_pkg::wbeat_s wbeat0_r;
  logic [sram_ddr_pkg::CNT_W-1:0] imp_cnt_r;
  logic [sram_ddr_pkg::CODE_W-1:0] code_r;
  logic [sram_ddr_pkg::CODE_W-1:0] code_nxt;

  logic k_rise;
  logic k_n_rise;
  logic c_tied;
  logic launch0;
  logic launch1;
  logic commit_now;
  sram_ddr_pkg::wbeat_s wbeat1;
  logic [sram_ddr_pkg::WORD_W-1:0] old_word;
  logic [sram_ddr_pkg::WORD_W-1:0] new_word;
  logic [sram_ddr_pkg::WORD_W-1:0] write_en;
  logic [sram_ddr_pkg::WORD_W-1:0] fetch_word;

  assign k_rise = k_in & ~k_prev_r;
  assign k_n_rise = k_n_in & ~k_n_prev_r;
  // Both output clocks high means they are tied off, not merely between edges
  assign c_tied = c_in & c_n_in;
  assign launch0 = c_tied ? k_n_rise : (c_n_in & ~c_n_prev_r);
  assign launch1 = c_tied ? k_rise : (c_in & ~c_prev_r);

  assign commit_now = k_n_rise & wr_pend_r;
  assign wbeat1 = '{data: data_in, mask: lane_write_mask, nmask: nibble_write_mask};
  assign old_word = mem[addr_in];
  // Low half of the word holds beat one, high half beat two
  assign write_en = {beat_enable(wbeat1, nibble_mode), beat_enable(wbeat0_r, nibble_mode)};
  assign new_word = (old_word & ~write_en) | ({data_in, wbeat0_r.data} & write_en);
  // Fetch waits for the next input-clock rise, after the matching write has committed,
  // so a same-cycle write passes through without a bypass path
  assign fetch_word = mem[rd_stage_r.addr];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      k_prev_r <= 1'b0;
      k_n_prev_r <= 1'b0;
      c_prev_r <= 1'b0;
      c_n_prev_r <= 1'b0;
    end else if (ce) begin
      k_prev_r <= k_in;
      k_n_prev_r <= k_n_in;
      c_prev_r <= c_in;
      c_n_prev_r <= c_n_in;
    end
  end

  // Read address pipeline and array fetch
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_stage_r <= '0;
      out_stage_r <= '0;
    end else if (ce && k_rise) begin
      rd_stage_r <= '{valid: ~read_select_n, addr: addr_in};
      out_stage_r <= '{valid: rd_stage_r.valid, data: fetch_word};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_r <= sram_ddr_pkg::PH_IDLE;
    end else if (ce) begin
      case (phase_r)
        sram_ddr_pkg::PH_IDLE: begin
          if (k_rise) begin
            phase_r <= sram_ddr_pkg::PH_ARMED;
          end
        end
        sram_ddr_pkg::PH_ARMED: begin
          if (launch0) begin
            phase_r <= sram_ddr_pkg::PH_IDLE;
          end
        end
        default: begin
          phase_r <= sram_ddr_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Output beats; deselected slots launch with the driver off
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q_r <= '0;
      q_oe_r <= 1'b0;
      beat1_hold_r <= '0;
      beat1_valid_r <= 1'b0;
      beat1_pend_r <= 1'b0;
      kn_seen_r <= 1'b0;
      kn_after_k_r <= 1'b0;
    end else if (ce) begin
      // A delayed c_n launch lands after the k_n rise of its slot, so that rise is
      // remembered from the fetch onward and handed to beat two at launch time
      if (k_rise) begin
        kn_after_k_r <= 1'b0;
      end else if (k_n_rise) begin
        kn_after_k_r <= 1'b1;
      end
      if (k_n_rise) begin
        kn_seen_r <= 1'b1;
      end
      if (launch1 && beat1_pend_r && kn_seen_r) begin
        q_r <= beat1_hold_r;
        q_oe_r <= beat1_valid_r;
        beat1_pend_r <= 1'b0;
      end
      if (launch0 && phase_r == sram_ddr_pkg::PH_ARMED) begin
        q_r <= out_stage_r.data[sram_ddr_pkg::DATA_W-1:0];
        q_oe_r <= out_stage_r.valid;
        beat1_hold_r <= out_stage_r.data[sram_ddr_pkg::WORD_W-1:sram_ddr_pkg::DATA_W];
        beat1_valid_r <= out_stage_r.valid;
        beat1_pend_r <= 1'b1;
        // In tied mode the launching edge is itself the input-clock-n rise
        kn_seen_r <= c_tied | k_n_rise | kn_after_k_r;
      end
    end
  end

  // Write port: command and beat one on input-clock, address and beat two on its complement
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wbeat0_r <= '0;
    end else if (ce) begin
      if (k_rise) begin
        wr_pend_r <= ~write_select_n;
        wbeat0_r <= '{data: data_in, mask: lane_write_mask, nmask: nibble_write_mask};
      end else if (k_n_rise) begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (ce && commit_now) begin
      mem[addr_in] <= new_word;
    end
  end

  // Drive strength: one step per evaluation, saturating at CODE_MIN and CODE_MAX; a single comparator gives direction only
  always_comb begin
    code_nxt = code_r;
    if (imp_above_ref && code_r != sram_ddr_pkg::CODE_MAX) begin
      code_nxt = code_r + 5'h01;
    end else if (!imp_above_ref && code_r != sram_ddr_pkg::CODE_MIN) begin
      code_nxt = code_r - 5'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      imp_cnt_r <= '0;
      code_r <= sram_ddr_pkg::CODE_RESET;
    end else if (ce) begin
      if (imp_cnt_r == sram_ddr_pkg::IMP_LAST) begin
        imp_cnt_r <= '0;
        code_r <= code_nxt;
      end else begin
        imp_cnt_r <= imp_cnt_r + 12'h001;
      end
    end
  end

  assign q_out = q_r;
  assign q_oe = q_oe_r;
  assign drive_code = code_r;

  a_read_capture: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && k_rise && !read_select_n) |=> (rd_stage_r.valid && rd_stage_r.addr == $past(addr_in)))
    else $error("read request not captured");

  a_beat0_launch: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && launch0 && phase_r == sram_ddr_pkg::PH_ARMED && out_stage_r.valid)
    |=> (q_oe_r && q_r == $past(out_stage_r.data[sram_ddr_pkg::DATA_W-1:0])))
    else $error("first read beat not launched");

  a_deselect_hiz: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && launch0 && phase_r == sram_ddr_pkg::PH_ARMED && !out_stage_r.valid) |=> !q_oe_r)
    else $error("deselect slot drove the outputs");

  a_tied_clocks: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && c_tied && k_n_rise && phase_r == sram_ddr_pkg::PH_ARMED)
    |=> (beat1_pend_r && kn_seen_r && phase_r == sram_ddr_pkg::PH_IDLE))
    else $error("input clock did not launch in tied mode");

  a_write_capture: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && k_rise && !write_select_n) |=> (wr_pend_r && wbeat0_r.data == $past(data_in)))
    else $error("write command or beat one lost");

  a_write_deselect: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && k_rise && write_select_n) |=> !wr_pend_r)
    else $error("deselect left a write pending");

  a_lane_kept: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && commit_now && !nibble_mode && lane_write_mask[0])
    |=> mem[$past(addr_in)][sram_ddr_pkg::DATA_W +: sram_ddr_pkg::LANE_W]
        == $past(old_word[sram_ddr_pkg::DATA_W +: sram_ddr_pkg::LANE_W]))
    else $error("masked lane was overwritten");

  a_imp_restart: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && imp_cnt_r == sram_ddr_pkg::IMP_LAST) |=> (imp_cnt_r == '0))
    else $error("evaluation counter did not restart");

  a_one_step: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (code_r == $past(code_r) || code_r == $past(code_r) + 5'h01
         || code_r == $past(code_r) - 5'h01))
    else $error("drive code moved more than one step");

  a_same_addr_forward: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && commit_now && rd_stage_r.valid && addr_in == rd_stage_r.addr)
    |=> mem[rd_stage_r.addr] == $past(new_word))
    else $error("same-cycle write not passed through to the read");

  a_beat1_launch: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && launch1 && beat1_pend_r && kn_seen_r && beat1_valid_r
     && !(launch0 && phase_r == sram_ddr_pkg::PH_ARMED))
    |=> (q_oe_r && q_r == $past(beat1_hold_r)))
    else $error("second read beat not launched");

  a_beat1_hiz: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && launch1 && beat1_pend_r && kn_seen_r && !beat1_valid_r
     && !(launch0 && phase_r == sram_ddr_pkg::PH_ARMED)) |=> !q_oe_r)
    else $error("deselect second beat drove the outputs");

  a_first_beat_low: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && commit_now && !nibble_mode && lane_write_mask == '0 && wbeat0_r.mask == '0)
    |=> mem[$past(addr_in)] == $past({data_in, wbeat0_r.data}))
    else $error("write beats not paired into one word");

  a_nibble_kept: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && commit_now && nibble_mode)
    |=> mem[$past(addr_in)][sram_ddr_pkg::DATA_W-1:sram_ddr_pkg::NIBS*sram_ddr_pkg::NIB_W]
        == $past(old_word[sram_ddr_pkg::DATA_W-1:sram_ddr_pkg::NIBS*sram_ddr_pkg::NIB_W]))
    else $error("bits above the nibble lanes were written");

  a_ce_freeze: assert property (@(posedge ref_clk) disable iff (reset)
    !ce |=> ($stable(imp_cnt_r) && $stable(code_r) && $stable(q_oe_r)
             && $stable(wr_pend_r) && $stable(phase_r)))
    else $error("state moved while the clock enable was low");

  a_code_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && imp_cnt_r != sram_ddr_pkg::IMP_LAST) |=> code_r == $past(code_r))
    else $error("drive code moved between evaluations");

  a_phase_disarm: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && launch0 && phase_r == sram_ddr_pkg::PH_ARMED) |=> phase_r == sram_ddr_pkg::PH_IDLE)
    else $error("read slot stayed armed after its first beat");

  c_read_burst: cover property (@(posedge ref_clk) disable iff (reset)
    (ce && launch0 && out_stage_r.valid) ##[1:40] (ce && launch1 && beat1_pend_r));
  c_masked_write: cover property (@(posedge ref_clk) disable iff (reset)
    ce && commit_now && wbeat0_r.mask != '0);
  c_tied_mode: cover property (@(posedge ref_clk) disable iff (reset)
    ce && c_tied && launch1 && beat1_pend_r);
  c_code_step: cover property (@(posedge ref_clk) disable iff (reset)
    ce && imp_cnt_r == sram_ddr_pkg::IMP_LAST && code_nxt != code_r);
  c_pass_through: cover property (@(posedge ref_clk) disable iff (reset)
    ce && commit_now && rd_stage_r.valid && addr_in == rd_stage_r.addr);
endmodule

/* File: shared/sram_ddr_pkg.sv */
/*
  Shared constants and carriers for the burst-of-two separate-I/O DDR SRAM core.
  Assumes a single reference clock at 100 MHz. The memory clocks are sampled as plain inputs.
*/
package sram_ddr_pkg;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int NIB_W = 4;
  localparam int NIBS = 2;
  localparam int ADDR_W = 8;
  localparam int WORD_W = 2 * DATA_W;
  localparam int DEPTH = 256;
  localparam int CODE_W = 5;
  localparam int CNT_W = 12;
  localparam logic [CODE_W-1:0] CODE_RESET = 5'h10;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h1F;
  localparam logic [CODE_W-1:0] CODE_MIN = 5'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int IMP_INTERVAL_NS = 10000;
  localparam int IMP_INTERVAL_CYC =
    (IMP_INTERVAL_NS / CLK_PERIOD_NS) < 1 ? 1 : (IMP_INTERVAL_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] IMP_LAST = CNT_W'(IMP_INTERVAL_CYC - 1);

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] mask;
    logic [NIBS-1:0] nmask;
  } wbeat_s;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } rd_req_s;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } rd_data_s;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_ARMED = 1'b1
  } beat_phase_e;
endpackage

/* File: sim/sram_ctrl_model.sv */
/*
  Memory controller model: drives input and output clocks, selects, address, data, masks.
  Assumes the bench calls op once per input-clock period of eight ref_clk cycles.
*/
`timescale 1ns/100ps
module sram_ctrl_model (
  input wire logic ref_clk,
  input wire logic run_c,
  input wire logic [sram_ddr_pkg::DATA_W-1:0] q_out,
  input wire logic q_oe,
  output logic k_in,
  output logic k_n_in,
  output logic c_in,
  output logic c_n_in,
  output logic read_select_n,
  output logic write_select_n,
  output logic [sram_ddr_pkg::ADDR_W-1:0] addr_in,
  output logic [sram_ddr_pkg::DATA_W-1:0] data_in,
  output logic [sram_ddr_pkg::LANES-1:0] lane_write_mask,
  output logic [sram_ddr_pkg::NIBS-1:0] nibble_write_mask
);
  logic [sram_ddr_pkg::DATA_W-1:0] beat1;
  logic [sram_ddr_pkg::DATA_W-1:0] beat2;
  logic oe1;
  logic oe2;

  // Input clocks low at reset release, so no false rise
  initial begin
    {k_in, k_n_in, addr_in, data_in, lane_write_mask, nibble_write_mask} = '0;
    {c_in, c_n_in, read_select_n, write_select_n} = 4'hF;
  end

  // Data and masks travel together, one set per beat
  task automatic put(input sram_ddr_pkg::wbeat_s b);
    {data_in, lane_write_mask, nibble_write_mask} = b;
  endtask

  // Past hold time show the inverse, so a stale value never passes for a valid one
  task automatic flip();
    {data_in, lane_write_mask, nibble_write_mask} = ~{data_in, lane_write_mask, nibble_write_mask};
    addr_in = ~addr_in;
    {read_select_n, write_select_n} = ~{read_select_n, write_select_n};
  endtask

  // Command on the k rise, write address half a period later on the k_n rise
  task automatic op(input logic rd_n, input logic [7:0] ra, input logic wr_n,
                    input logic [7:0] wa, input sram_ddr_pkg::wbeat_s b0,
                    input sram_ddr_pkg::wbeat_s b1);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #1;
      case (i)
        0: begin
          {k_in, k_n_in, read_select_n, write_select_n, addr_in} = {2'b10, rd_n, wr_n, ra};
          put(b0);
        end
        1: {c_in, c_n_in} = {1'b1, !run_c};
        2: flip();
        3: {beat2, oe2} = {q_out, q_oe};
        4: begin
          {k_in, k_n_in, addr_in} = {2'b01, wa};
          put(b1);
        end
        5: begin
          {c_in, c_n_in} = {!run_c, 1'b1};
          flip();
        end
        7: {beat1, oe1} = {q_out, q_oe};
        default: ;
      endcase
    end
  endtask
endmodule

/* File: sim/ddr_burst2_separate_io_sram_test.sv */
/*
  Self-checking bench for the DDR SRAM core, driven through the controller model.
  Assumes the core launches beats one ref_clk after each sampled launch edge.
*/
`timescale 1ns/100ps
module ddr_burst2_separate_io_sram_test;
  logic ref_clk;
  logic reset;
  logic ce;
  logic nibble_mode;
  logic imp_above_ref;
  logic run_c;
  logic k_in;
  logic k_n_in;
  logic c_in;
  logic c_n_in;
  logic read_select_n;
  logic write_select_n;
  logic [7:0] addr_in;
  logic [17:0] data_in;
  logic [1:0] lane_write_mask;
  logic [1:0] nibble_write_mask;
  logic [17:0] q_out;
  logic q_oe;
  logic [4:0] drive_code;
  int n_errors = 0;
  int n_checks = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  sram_ddr_core dut (.ref_clk, .reset, .ce, .k_in, .k_n_in, .c_in, .c_n_in, .read_select_n,
    .write_select_n, .addr_in, .data_in, .lane_write_mask, .nibble_write_mask, .nibble_mode,
    .imp_above_ref, .q_out, .q_oe, .drive_code);
  sram_ctrl_model ctl (.ref_clk, .run_c, .q_out, .q_oe, .k_in, .k_n_in, .c_in, .c_n_in,
    .read_select_n, .write_select_n, .addr_in, .data_in, .lane_write_mask, .nibble_write_mask);

  function automatic sram_ddr_pkg::wbeat_s mk(input logic [17:0] d, input logic [3:0] m);
    mk = {d, m};
  endfunction

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle();
    ctl.op(1'b1, 8'h00, 1'b1, 8'h00, mk(18'h0, 4'h0), mk(18'h0, 4'h0));
  endtask

  task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1, input logic [3:0] m0, m1);
    ctl.op(1'b1, 8'h00, 1'b0, a, mk(d0, m0), mk(d1, m1));
  endtask

  task automatic rd(input logic [7:0] a, input logic [17:0] e1, e2);
    ctl.op(1'b0, a, 1'b1, 8'h00, mk(18'h0, 4'h0), mk(18'h0, 4'h0));
    idle();
    chk({ctl.beat1[16:0], ctl.oe1}, {e1[16:0], 1'b1});
    chk(ctl.beat1, e1);
    idle();
    chk({ctl.beat2[16:0], ctl.oe2}, {e2[16:0], 1'b1});
    chk(ctl.beat2, e2);
  endtask

  task automatic t_write_read();
    wr(8'h12, 18'h0ABCD, 18'h31234, 4'h0, 4'h0);
    rd(8'h12, 18'h0ABCD, 18'h31234);
    wr(8'h12, 18'h3FFFF, 18'h3FFFF, 4'h0, 4'h0);
    ctl.op(1'b1, 8'h00, 1'b1, 8'h12, mk(18'h0, 4'h0), mk(18'h0, 4'h0));
    rd(8'h12, 18'h3FFFF, 18'h3FFFF);
    ce = 1'b0;
    wr(8'h12, 18'h00000, 18'h00000, 4'h0, 4'h0);
    ce = 1'b1;
    rd(8'h12, 18'h3FFFF, 18'h3FFFF);
    idle();
    idle();
    chk({17'h0, ctl.oe1 | ctl.oe2}, 18'h0);
    $display("test write_read done");
  endtask

  task automatic t_masks();
    wr(8'h20, 18'h15555, 18'h2AAAA, 4'h0, 4'h0);
    wr(8'h20, 18'h3FFFF, 18'h00000, 4'h8, 4'h4);
    rd(8'h20, {9'h0AA, 9'h1FF}, {9'h000, 9'h0AA});
    $display("test masks done");
  endtask

  task automatic t_out_clocks();
    run_c = 1'b1;
    wr(8'h33, 18'h00F0F, 18'h3C3C3, 4'h0, 4'h0);
    rd(8'h33, 18'h00F0F, 18'h3C3C3);
    run_c = 1'b0;
    $display("test out_clocks done");
  endtask

  task automatic t_pass_through();
    wr(8'h40, 18'h11111, 18'h22222, 4'h0, 4'h0);
    ctl.op(1'b0, 8'h12, 1'b0, 8'h41, mk(18'h05A5A, 4'h0), mk(18'h3A5A5, 4'h0));
    rd(8'h41, 18'h05A5A, 18'h3A5A5);
    ctl.op(1'b0, 8'h40, 1'b0, 8'h40, mk(18'h0BEEF, 4'h0), mk(18'h3CAFE, 4'h0));
    idle();
    chk(ctl.beat1, 18'h0BEEF);
    idle();
    chk(ctl.beat2, 18'h3CAFE);
    $display("test pass_through done");
  endtask

  task automatic t_nibble();
    wr(8'h50, 18'h3FF00, 18'h3FF00, 4'h0, 4'h0);
    nibble_mode = 1'b1;
    wr(8'h50, 18'h000AB, 18'h000CD, 4'hD, 4'hE);
    rd(8'h50, 18'h3FFA0, 18'h3FF0D);
    nibble_mode = 1'b0;
    $display("test nibble done");
  endtask

  task automatic t_impedance();
    int ups;
    int downs;
    int bad;
    logic [4:0] prev;
    {ups, downs, bad} = '0;
    imp_above_ref = 1'b1;
    prev = drive_code;
    for (int i = 0; i < 3000; i++) begin
      @(posedge ref_clk);
      #1;
      if (i == 1999) imp_above_ref = 1'b0;
      if (drive_code === prev + 5'h01) ups++;
      else if (drive_code === prev - 5'h01) downs++;
      else if (drive_code !== prev) bad++;
      prev = drive_code;
    end
    chk(18'(ups), 18'h00002);
    chk(18'(downs), 18'h00001);
    chk(18'(bad), 18'h00000);
    $display("test impedance done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Tests take about 3300 cycles; twice that means a hang
  initial begin
    repeat (7000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end

  initial begin
    {reset, ce, nibble_mode, imp_above_ref, run_c} = 5'b11000;
    repeat (8) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk({12'h0, q_oe, drive_code}, 18'h00010);
    t_write_read();
    t_masks();
    t_out_clocks();
    t_pass_through();
    t_nibble();
    t_impedance();
    summarize();
  end
endmodule
